// ==== bench/dascc_dbg_model.sv ====
// External debugger model issuing single-cycle requests on the debug register port
`timescale 1ns/1ps
`default_nettype none
module dascc_dbg_model (
    input  wire logic        sys_clk,
    output var logic         dbg_req,
    output var logic         dbg_comp,
    output var logic         dbg_write,
    output var logic  [11:0] dbg_addr,
    output var logic  [31:0] dbg_wdata
);
    initial begin
        dbg_req   = 1'h0;
        dbg_comp  = 1'h0;
        dbg_write = 1'h0;
        dbg_addr  = 12'h0;
        dbg_wdata = 32'h0;
    end

    // Qualifiers flip after the pulse so a stale value never passes as valid
    task automatic acc(input logic c, input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        dbg_req   <= 1'h1;
        dbg_comp  <= c;
        dbg_write <= w;
        dbg_addr  <= a;
        dbg_wdata <= d;
        @(posedge sys_clk);
        dbg_req   <= 1'h0;
        dbg_comp  <= ~c;
        dbg_write <= ~w;
        dbg_addr  <= ~a;
        dbg_wdata <= ~d;
    endtask : acc
endmodule : dascc_dbg_model
`default_nettype wire

// ==== bench/dascc_tb_top.sv ====
// Self-checking bench: status words, register port answers and realm catch control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_fail++; \
    $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
module debug_auth_status_catch_ctrl_tb_top;
    localparam logic [31:0] M = 32'h0076_0000;
    logic        sys_clk, reset, ns, inv, ninv, sinv, sninv, rinv, rtinv, pwr, cwr;
    logic [31:0] cwd, w;
    wire  logic  req, comp, wr, ack, err;
    wire  logic [11:0] addr;
    wire  logic [31:0] wd, rd, catch_w, auth, cti, b_auth, b_cti, b_catch, c_auth;
    wire  logic  e2e, e2r, e1e, e1r, e0r;
    logic [32:0] q[$];
    int          n_fail = 0, samples_checked = 0;

    dascc_dbg_model i_dbg (.sys_clk(sys_clk), .dbg_req(req), .dbg_comp(comp),
        .dbg_write(wr), .dbg_addr(addr), .dbg_wdata(wd));
    dascc_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .effective_nonsecure_state_bit(ns),
        .invasive_en(inv), .noninvasive_en(ninv), .secure_invasive_en(sinv),
        .secure_noninvasive_en(sninv), .realm_invasive_en(rinv), .root_invasive_en(rtinv),
        .core_powered(pwr), .dbg_req(req), .dbg_comp(comp), .dbg_write(wr), .dbg_addr(addr),
        .dbg_wdata(wd), .dbg_ack(ack), .dbg_err(err), .dbg_rdata(rd), .sys_catch_wr(cwr),
        .sys_catch_wdata(cwd), .sys_catch_rdata(catch_w), .sys_auth_status(auth),
        .cti_auth_status(cti), .realm_el2_entry_en(e2e), .realm_el2_return_en(e2r),
        .realm_el1_entry_en(e1e), .realm_el1_return_en(e1r), .realm_el0_return_en(e0r));
    // No EL3 and no realm option, fed from the same stimulus
    dascc_ctrl #(.EL3_IMPL(1'b0), .REALM_OPT(1'b0)) i_dut_b (.sys_clk(sys_clk), .reset(reset),
        .effective_nonsecure_state_bit(ns), .invasive_en(inv), .noninvasive_en(ninv),
        .secure_invasive_en(sinv), .secure_noninvasive_en(sninv), .realm_invasive_en(rinv),
        .root_invasive_en(rtinv), .core_powered(pwr), .dbg_req(req), .dbg_comp(comp),
        .dbg_write(wr), .dbg_addr(addr), .dbg_wdata(wd), .dbg_ack(), .dbg_err(),
        .dbg_rdata(), .sys_catch_wr(cwr), .sys_catch_wdata(cwd), .sys_catch_rdata(b_catch),
        .sys_auth_status(b_auth), .cti_auth_status(b_cti), .realm_el2_entry_en(),
        .realm_el2_return_en(), .realm_el1_entry_en(), .realm_el1_return_en(),
        .realm_el0_return_en());
    // Older debug version without EL2: secure non-invasive has its own enable
    dascc_ctrl #(.EL2_IMPL(1'b0), .NEWER_DBG(1'b0)) i_dut_c (.sys_clk(sys_clk), .reset(reset),
        .effective_nonsecure_state_bit(ns), .invasive_en(inv), .noninvasive_en(ninv),
        .secure_invasive_en(sinv), .secure_noninvasive_en(sninv), .realm_invasive_en(rinv),
        .root_invasive_en(rtinv), .core_powered(pwr), .dbg_req(req), .dbg_comp(comp),
        .dbg_write(wr), .dbg_addr(addr), .dbg_wdata(wd), .dbg_ack(), .dbg_err(),
        .dbg_rdata(), .sys_catch_wr(cwr), .sys_catch_wdata(cwd), .sys_catch_rdata(),
        .sys_auth_status(c_auth), .cti_auth_status(), .realm_el2_entry_en(),
        .realm_el2_return_en(), .realm_el1_entry_en(), .realm_el1_return_en(),
        .realm_el0_return_en());

    initial sys_clk = 1'h0;
    always #50 sys_clk = ~sys_clk;

    function automatic logic [1:0] cd(input logic p, input logic e);
        return p ? {1'h1, e} : 2'h0;
    endfunction : cd

    function automatic logic [31:0] ea(input logic el3, input logic el2, input logic rl,
                                       input logic nd = 1'h1);
        logic [1:0] ni, nn, si, sn, li, ti;
        ni = cd(el3 | ns, inv);
        nn = (nd & (ns | (el3 & ~el2))) ? 2'h3 : cd(el3 | ns, ninv);
        si = cd(el3 | ~ns, sinv);
        sn = nd ? si : cd(el3 | ~ns, sninv);
        li = cd(rl, rinv);
        ti = cd(rl, rtinv);
        return {4'h0, ti, ti, 8'h0, li, li, 4'h0, sn, si, nn, ni};
    endfunction : ea

    function automatic logic [31:0] ec(input logic el3, input logic el2);
        logic [31:0] a;
        a = ea(el3, el2, 1'h0);
        return (el3 | ns) ? {28'h0, a[3:0]} : {28'h0, a[7:4]};
    endfunction : ec

    task automatic xa(input logic c, input logic wr_, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] ex);
        q.push_back(ex);
        i_dbg.acc(c, wr_, a, d);
    endtask : xa

    task automatic chk_catch(input logic [31:0] v);
        @(negedge sys_clk);
        `CHK("catch word", v & M, catch_w)
        `CHK("realm enables", {v[18], v[22] ^ v[18], v[17], v[21] ^ v[17], v[20]},
             {e2e, e2r, e1e, e1r, e0r})
        `CHK("catch without realm", 32'h0, b_catch)
    endtask : chk_catch

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Answer checker: every ack takes the oldest expectation
    always @(negedge sys_clk) begin : mon
        logic [32:0] e;
        if (ack === 1'h1) begin
            e = (q.size() > 0) ? q.pop_front() : 33'h1_dead_beef;
            `CHK("dbg answer", e, {err, rd})
        end
    end

    initial begin
        #500000;
        `CHK("watchdog", 1'h0, 1'h1)
        end_sim();
    end

    initial begin
        {ns, inv, ninv, sinv, sninv, rinv, rtinv, cwr} = 8'h0;
        pwr = 1'h1;
        cwd = 32'h0;
        reset = 1'h1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'h0;
        void'($urandom(25));
        chk_catch(32'h0);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            @(posedge sys_clk);
            {ns, inv, ninv, sinv, sninv, rinv, rtinv} <= 7'($urandom);
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            `CHK("debug status", ea(1'h1, 1'h1, 1'h1), auth)
            `CHK("cti status", ec(1'h1, 1'h1), cti)
            `CHK("status no el3", ea(1'h0, 1'h1, 1'h0), b_auth)
            `CHK("cti no el3", ec(1'h0, 1'h1), b_cti)
            `CHK("status old debug", ea(1'h1, 1'h0, 1'h1, 1'h0), c_auth)
            xa(1'h1, 1'h0, 12'hfb8, 32'h0, {1'h0, ea(1'h1, 1'h1, 1'h1)});
            xa(1'h0, 1'h0, 12'hfb8, 32'h0, {1'h0, ec(1'h1, 1'h1)});
        end
        $display("test status done");
        xa(1'h1, 1'h1, 12'hfb8, $urandom, 33'h0);
        xa(1'h0, 1'h1, 12'hfb8, $urandom, 33'h0);
        xa(1'h1, 1'h0, 12'hfb8, 32'h0, {1'h0, ea(1'h1, 1'h1, 1'h1)});
        xa(1'h0, 1'h0, 12'h010, 32'h0, 33'h0);
        pwr <= 1'h0;
        xa(1'h1, 1'h0, 12'hfb8, 32'h0, 33'h1_0000_0000);
        xa(1'h1, 1'h1, 12'hfb8, 32'h0, 33'h1_0000_0000);
        xa(1'h0, 1'h0, 12'hfb8, 32'h0, {1'h0, ec(1'h1, 1'h1)});
        pwr <= 1'h1;
        $display("test access kinds done");
        for (int k = 0; k < 8; k++) begin
            w = $urandom;
            {w[22], w[17], w[20]} = {3{k[0]}};
            {w[18], w[21]} = {2{k[1]}};
            if (k[2]) begin
                @(posedge sys_clk);
                cwr <= 1'h1;
                cwd <= w;
                @(posedge sys_clk);
                cwr <= 1'h0;
                cwd <= ~w;
                repeat (2) @(posedge sys_clk);
                xa(1'h1, 1'h0, 12'h098, 32'h0, {1'h0, w & M});
            end else begin
                xa(1'h1, 1'h1, 12'h098, w, 33'h0);
                xa(1'h1, 1'h0, 12'h098, 32'h0, {1'h0, w & M});
            end
            chk_catch(w);
        end
        $display("test catch done");
        @(posedge sys_clk);
        reset <= 1'h1;
        @(posedge sys_clk);
        reset <= 1'h0;
        chk_catch(32'h0);
        repeat (3) @(posedge sys_clk);
        `CHK("pending answers", 0, q.size())
        $display("test cold reset done");
        end_sim();
    end
endmodule : debug_auth_status_catch_ctrl_tb_top
`default_nettype wire

// ==== include/dascc_pkg.sv ====
// Constants, field layout and decode helpers for the debug authentication and catch block
// Functional notes
// R1 - Cross-trigger status [1:0] copies non-secure invasive, or secure invasive without EL3 when the non-secure state bit is 0.
// R2 - Cross-trigger status sits at 0xfb8 of the cross-trigger component, read only.
// R3 - Debug status is 32 bits, one storage seen externally and by the processor.
// R4 - Root non-invasive [27:26] equals root invasive; both 00 without realm option.
// R5 - Fields encode 00 absent, 10 disabled, 11 enabled; 01 never produced.
// R6 - Realm non-invasive [15:14] equals realm invasive [13:12], from realm enable.
// R7 - With newer debug, secure non-invasive copies secure invasive; else own enable.
// R8 - Secure fields read 00 when EL3 absent and non-secure state bit is 1.
// R9 - Non-secure fields read 00 when EL3 absent and non-secure state bit is 0.
// R10 - Newer debug: non-secure non-invasive reads 11 if NS=1 or EL3 without EL2.
// R11 - Non-secure invasive [1:0] follows the external invasive enable.
// R12 - Debug status at 0xfb8 of debug component, read only; error when core unpowered.
// R13 - Debug status lives in core power domain with option, else debug domain.
// R14 - Catch control is 32 bits, one storage shared with the processor view.
// R15 - Realm EL2 (return,entry): 00 off, 01 both, 10 return only, 11 entry only.
// R16 - Realm EL1 uses the same scheme with return bit 21 and its entry bit.
// R17 - Bit 20 enables catch on returns to Realm EL0.
// R18 - Realm catch bits clear on cold reset; read zero without realm option.
// R19 - Realm EL2 entry bit sits at 18, paired with the EL2 return bit.
// R20 - Status fields derive from live enable inputs every cycle, no software writes.
package dascc_pkg;

    localparam logic [11:0] DASCC_AUTH_OFF  = 12'hfb8;
    localparam logic [11:0] DASCC_CATCH_OFF = 12'h098;
    localparam logic        DASCC_COMP_CTI  = 1'h0;
    localparam logic        DASCC_COMP_DBG  = 1'h1;

    localparam int DASCC_NS_INV_LSB     = 0;
    localparam int DASCC_NS_NONINV_LSB  = 2;
    localparam int DASCC_SEC_INV_LSB    = 4;
    localparam int DASCC_SEC_NONINV_LSB = 6;
    localparam int DASCC_RL_INV_LSB     = 12;
    localparam int DASCC_RL_NONINV_LSB  = 14;
    localparam int DASCC_RT_INV_LSB     = 24;
    localparam int DASCC_RT_NONINV_LSB  = 26;

    localparam int DASCC_EL2_RET_BIT = 22;
    localparam int DASCC_EL1_RET_BIT = 21;
    localparam int DASCC_EL0_RET_BIT = 20;
    localparam int DASCC_EL2_ENT_BIT = 18;
    localparam int DASCC_EL1_ENT_BIT = 17;

    localparam logic [1:0]  DASCC_CODE_ABSENT = 2'h0;
    localparam logic [1:0]  DASCC_CODE_OFF    = 2'h2;
    localparam logic [1:0]  DASCC_CODE_ON     = 2'h3;
    localparam logic [31:0] DASCC_WORD_ZERO   = 32'h0;
    localparam logic        DASCC_BIT_RESET   = 1'h0;

    // Only three codes can come out, so the reserved 01 is unreachable
    function automatic logic [1:0] dascc_auth_code(input logic present, input logic enabled);
        if (!present) begin
            return DASCC_CODE_ABSENT;
        end
        return enabled ? DASCC_CODE_ON : DASCC_CODE_OFF;
    endfunction : dascc_auth_code

    // Returns {entry_enable, return_enable} from the paired return and entry bits
    function automatic logic [1:0] dascc_catch_decode(input logic ret, input logic ent);
        unique case ({ret, ent})
            2'h0:    return 2'h0;
            2'h1:    return 2'h3;
            2'h2:    return 2'h1;
            default: return 2'h2;
        endcase
    endfunction : dascc_catch_decode

endpackage : dascc_pkg

// ==== rtl/dascc_catch_store.sv ====
// Realm catch bit storage shared by the external and processor views
`timescale 1ns/1ps
`default_nettype none
module dascc_catch_store #(
    parameter bit REALM_OPT = 1'b1
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        ext_wr,
    input  wire logic [31:0] ext_wdata,
    input  wire logic        sys_wr,
    input  wire logic [31:0] sys_wdata,
    output logic      [31:0] catch_word
);

    typedef struct packed {
        logic el2_ret;
        logic el1_ret;
        logic el0_ret;
        logic el2_ent;
        logic el1_ent;
    } dascc_store_t;

    dascc_store_t st;
    dascc_store_t next_st;
    logic [31:0]  wsel;

    always_comb begin
        next_st = st;
        // External port wins a same-cycle collision
        wsel = ext_wr ? ext_wdata : sys_wdata;
        if (REALM_OPT && (ext_wr || sys_wr)) begin // [R14] [R18]
            next_st.el2_ret = wsel[dascc_pkg::DASCC_EL2_RET_BIT]; // [R15]
            next_st.el1_ret = wsel[dascc_pkg::DASCC_EL1_RET_BIT]; // [R16]
            next_st.el0_ret = wsel[dascc_pkg::DASCC_EL0_RET_BIT]; // [R17]
            next_st.el2_ent = wsel[dascc_pkg::DASCC_EL2_ENT_BIT]; // [R19]
            next_st.el1_ent = wsel[dascc_pkg::DASCC_EL1_ENT_BIT]; // [R16]
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '{default: dascc_pkg::DASCC_BIT_RESET}; // [R18]
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        catch_word = dascc_pkg::DASCC_WORD_ZERO;
        catch_word[dascc_pkg::DASCC_EL2_RET_BIT] = st.el2_ret;
        catch_word[dascc_pkg::DASCC_EL1_RET_BIT] = st.el1_ret;
        catch_word[dascc_pkg::DASCC_EL0_RET_BIT] = st.el0_ret;
        catch_word[dascc_pkg::DASCC_EL2_ENT_BIT] = st.el2_ent;
        catch_word[dascc_pkg::DASCC_EL1_ENT_BIT] = st.el1_ent;
    end

    AST_CATCH_COLD_RESET: assert property (@(posedge sys_clk) // [R18]
        $fell(reset) |-> catch_word == dascc_pkg::DASCC_WORD_ZERO)
        else $error("catch bits not clear after cold reset");

endmodule : dascc_catch_store
`default_nettype wire

// ==== rtl/dascc_ctrl.sv ====
// Debug authentication status and realm exception catch control, external debug side
`timescale 1ns/1ps
`default_nettype none
module dascc_ctrl #(
    parameter bit EL3_IMPL   = 1'b1,
    parameter bit EL2_IMPL   = 1'b1,
    parameter bit REALM_OPT  = 1'b1,
    parameter bit NEWER_DBG  = 1'b1,
    parameter bit SEP_PD_OPT = 1'b1
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        effective_nonsecure_state_bit,
    input  wire logic        invasive_en,
    input  wire logic        noninvasive_en,
    input  wire logic        secure_invasive_en,
    input  wire logic        secure_noninvasive_en,
    input  wire logic        realm_invasive_en,
    input  wire logic        root_invasive_en,
    input  wire logic        core_powered,
    input  wire logic        dbg_req,
    input  wire logic        dbg_comp,
    input  wire logic        dbg_write,
    input  wire logic [11:0] dbg_addr,
    input  wire logic [31:0] dbg_wdata,
    output logic             dbg_ack,
    output logic             dbg_err,
    output logic      [31:0] dbg_rdata,
    input  wire logic        sys_catch_wr,
    input  wire logic [31:0] sys_catch_wdata,
    output logic      [31:0] sys_catch_rdata,
    output logic      [31:0] sys_auth_status,
    output logic      [31:0] cti_auth_status,
    output logic             realm_el2_entry_en,
    output logic             realm_el2_return_en,
    output logic             realm_el1_entry_en,
    output logic             realm_el1_return_en,
    output logic             realm_el0_return_en
);

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
        logic [31:0] dbg_auth;
        logic [31:0] cti_auth;
        logic [1:0]  el2_catch;
        logic [1:0]  el1_catch;
        logic        el0_catch;
    } dascc_state_t;

    dascc_state_t st;
    dascc_state_t next_st;

    logic [31:0] catch_word;
    logic        ext_catch_wr;
    logic        hit_auth;
    logic        hit_catch;
    logic        auth_blocked;
    logic [1:0]  f_ns_inv;
    logic [1:0]  f_ns_noninv;
    logic [1:0]  f_sec_inv;
    logic [1:0]  f_sec_noninv;
    logic [1:0]  f_rl_inv;
    logic [1:0]  f_rt_inv;
    logic        ns_absent;
    logic        sec_absent;

    // Same storage behind the external port and the processor view
    dascc_catch_store #(
        .REALM_OPT (REALM_OPT)
    ) u_store (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .ext_wr     (ext_catch_wr),
        .ext_wdata  (dbg_wdata),
        .sys_wr     (sys_catch_wr),
        .sys_wdata  (sys_catch_wdata),
        .catch_word (catch_word)
    );

    assign hit_auth     = dbg_addr == dascc_pkg::DASCC_AUTH_OFF;
    assign hit_catch    = dbg_addr == dascc_pkg::DASCC_CATCH_OFF;
    // The status word sits in the core power domain when the option exists
    assign auth_blocked = SEP_PD_OPT && !core_powered; // [R13]
    assign ext_catch_wr = dbg_req && dbg_write && hit_catch
                          && (dbg_comp == dascc_pkg::DASCC_COMP_DBG); // [R14]

    // Field derivation is purely from live inputs, sampled every cycle
    always_comb begin
        ns_absent  = !EL3_IMPL && !effective_nonsecure_state_bit; // [R9]
        sec_absent = !EL3_IMPL && effective_nonsecure_state_bit;  // [R8]
        f_ns_inv = dascc_pkg::dascc_auth_code(!ns_absent, invasive_en); // [R11] [R5]
        if (ns_absent) begin
            f_ns_noninv = dascc_pkg::DASCC_CODE_ABSENT; // [R9]
        end else if (NEWER_DBG && (effective_nonsecure_state_bit
                                   || (EL3_IMPL && !EL2_IMPL))) begin
            f_ns_noninv = dascc_pkg::DASCC_CODE_ON; // [R10]
        end else begin
            f_ns_noninv = dascc_pkg::dascc_auth_code(1'b1, noninvasive_en);
        end
        f_sec_inv = dascc_pkg::dascc_auth_code(!sec_absent, secure_invasive_en); // [R8]
        if (NEWER_DBG) begin
            f_sec_noninv = f_sec_inv; // [R7]
        end else begin
            f_sec_noninv = dascc_pkg::dascc_auth_code(!sec_absent, secure_noninvasive_en); // [R7]
        end
        f_rl_inv = dascc_pkg::dascc_auth_code(REALM_OPT, realm_invasive_en); // [R6]
        f_rt_inv = dascc_pkg::dascc_auth_code(REALM_OPT, root_invasive_en);  // [R4]
    end

    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;
        next_st.err = 1'b0;

        next_st.dbg_auth = dascc_pkg::DASCC_WORD_ZERO; // [R3] [R20]
        next_st.dbg_auth[dascc_pkg::DASCC_NS_INV_LSB     +: 2] = f_ns_inv;
        next_st.dbg_auth[dascc_pkg::DASCC_NS_NONINV_LSB  +: 2] = f_ns_noninv;
        next_st.dbg_auth[dascc_pkg::DASCC_SEC_INV_LSB    +: 2] = f_sec_inv;
        next_st.dbg_auth[dascc_pkg::DASCC_SEC_NONINV_LSB +: 2] = f_sec_noninv;
        next_st.dbg_auth[dascc_pkg::DASCC_RL_INV_LSB     +: 2] = f_rl_inv;
        next_st.dbg_auth[dascc_pkg::DASCC_RL_NONINV_LSB  +: 2] = f_rl_inv; // [R6]
        next_st.dbg_auth[dascc_pkg::DASCC_RT_INV_LSB     +: 2] = f_rt_inv;
        next_st.dbg_auth[dascc_pkg::DASCC_RT_NONINV_LSB  +: 2] = f_rt_inv; // [R4]

        next_st.cti_auth = dascc_pkg::DASCC_WORD_ZERO;
        if (!EL3_IMPL && !effective_nonsecure_state_bit) begin
            // Secure-only part reports its secure fields in the low nibble
            next_st.cti_auth[dascc_pkg::DASCC_NS_INV_LSB    +: 2] = f_sec_inv; // [R1]
            next_st.cti_auth[dascc_pkg::DASCC_NS_NONINV_LSB +: 2] = f_sec_noninv;
        end else begin
            next_st.cti_auth[dascc_pkg::DASCC_NS_INV_LSB    +: 2] = f_ns_inv;  // [R1]
            next_st.cti_auth[dascc_pkg::DASCC_NS_NONINV_LSB +: 2] = f_ns_noninv;
        end

        next_st.el2_catch = dascc_pkg::dascc_catch_decode(
            catch_word[dascc_pkg::DASCC_EL2_RET_BIT],
            catch_word[dascc_pkg::DASCC_EL2_ENT_BIT]); // [R15] [R19]
        next_st.el1_catch = dascc_pkg::dascc_catch_decode(
            catch_word[dascc_pkg::DASCC_EL1_RET_BIT],
            catch_word[dascc_pkg::DASCC_EL1_ENT_BIT]); // [R16]
        next_st.el0_catch = catch_word[dascc_pkg::DASCC_EL0_RET_BIT]; // [R17]

        if (dbg_req) begin
            next_st.ack   = 1'b1;
            next_st.rdata = dascc_pkg::DASCC_WORD_ZERO;
            // Writes to the status words are dropped; only reads return data
            if (dbg_comp == dascc_pkg::DASCC_COMP_CTI) begin
                if (hit_auth && !dbg_write) begin
                    next_st.rdata = st.cti_auth; // [R2]
                end
            end else if (hit_auth) begin
                if (auth_blocked) begin
                    next_st.err = 1'b1; // [R12]
                end else if (!dbg_write) begin
                    next_st.rdata = st.dbg_auth; // [R12]
                end
            end else if (hit_catch && !dbg_write) begin
                next_st.rdata = catch_word; // [R14]
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dbg_ack             = st.ack;
    assign dbg_err             = st.err;
    assign dbg_rdata           = st.rdata;
    assign sys_auth_status     = st.dbg_auth; // [R3]
    assign cti_auth_status     = st.cti_auth;
    assign sys_catch_rdata     = catch_word;
    assign realm_el2_entry_en  = st.el2_catch[1];
    assign realm_el2_return_en = st.el2_catch[0];
    assign realm_el1_entry_en  = st.el1_catch[1];
    assign realm_el1_return_en = st.el1_catch[0];
    assign realm_el0_return_en = st.el0_catch;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_auth_read;
        dbg_req && !dbg_write && hit_auth && dbg_comp == dascc_pkg::DASCC_COMP_DBG;
    endsequence

    sequence s_err_answer;
        dbg_ack && dbg_err && dbg_rdata == dascc_pkg::DASCC_WORD_ZERO;
    endsequence

    sequence s_cti_read;
        dbg_req && !dbg_write && hit_auth && dbg_comp == dascc_pkg::DASCC_COMP_CTI;
    endsequence

    AST_AUTH_ERROR: assert property ( // [R12]
        s_auth_read ##0 auth_blocked |=> s_err_answer)
        else $error("unpowered status access gave no error");

    AST_AUTH_READ: assert property ( // [R12]
        s_auth_read ##0 !auth_blocked |=> dbg_ack && !dbg_err
                                          && dbg_rdata == $past(sys_auth_status))
        else $error("status read data mismatch");

    AST_CTI_READ: assert property ( // [R2]
        s_cti_read |=> dbg_ack && !dbg_err && dbg_rdata == $past(cti_auth_status))
        else $error("cross-trigger status read mismatch");

    AST_ROOT_PAIR: assert property ( // [R4]
        sys_auth_status[dascc_pkg::DASCC_RT_NONINV_LSB +: 2]
            == sys_auth_status[dascc_pkg::DASCC_RT_INV_LSB +: 2])
        else $error("root fields differ");

    // Status flops sit at zero through reset; tracking checks start one edge after release
    AST_REALM_TRACK: assert property ( // [R6]
        !reset && REALM_OPT |=> sys_auth_status[dascc_pkg::DASCC_RL_NONINV_LSB +: 2]
            == {1'b1, $past(realm_invasive_en)}
            && sys_auth_status[dascc_pkg::DASCC_RL_INV_LSB +: 2]
            == {1'b1, $past(realm_invasive_en)})
        else $error("realm fields not tracking enable");

    AST_NO_RESERVED: assert property ( // [R5]
        sys_auth_status[dascc_pkg::DASCC_NS_INV_LSB +: 2] != 2'h1
        && sys_auth_status[dascc_pkg::DASCC_NS_NONINV_LSB +: 2] != 2'h1
        && sys_auth_status[dascc_pkg::DASCC_SEC_INV_LSB +: 2] != 2'h1
        && sys_auth_status[dascc_pkg::DASCC_SEC_NONINV_LSB +: 2] != 2'h1)
        else $error("reserved field code produced");

    AST_NONSECURE_INVASIVE_FIELD_FOLLOW: assert property ( // [R11]
        !reset && EL3_IMPL |=> sys_auth_status[dascc_pkg::DASCC_NS_INV_LSB +: 2]
            == {1'b1, $past(invasive_en)})
        else $error("non-secure invasive field wrong");

    AST_NONSECURE_NONINVASIVE_FIELD_ONES: assert property ( // [R10]
        !reset && NEWER_DBG && effective_nonsecure_state_bit
        |=> sys_auth_status[dascc_pkg::DASCC_NS_NONINV_LSB +: 2] == dascc_pkg::DASCC_CODE_ON)
        else $error("non-secure non-invasive not forced on");

    AST_SECURE_NONINVASIVE_FIELD_COPY: assert property ( // [R7]
        NEWER_DBG |-> sys_auth_status[dascc_pkg::DASCC_SEC_NONINV_LSB +: 2]
            == sys_auth_status[dascc_pkg::DASCC_SEC_INV_LSB +: 2])
        else $error("secure non-invasive not copying invasive");

    AST_SEC_ABSENT: assert property ( // [R8]
        !EL3_IMPL && effective_nonsecure_state_bit
        |=> sys_auth_status[dascc_pkg::DASCC_SEC_INV_LSB +: 4] == 4'h0)
        else $error("secure fields not absent");

    AST_NS_ABSENT: assert property ( // [R9]
        !EL3_IMPL && !effective_nonsecure_state_bit
        |=> sys_auth_status[dascc_pkg::DASCC_NS_INV_LSB +: 4] == 4'h0)
        else $error("non-secure fields not absent");

    AST_CTI_LOW: assert property ( // [R1]
        EL3_IMPL |-> cti_auth_status[dascc_pkg::DASCC_NS_INV_LSB +: 2]
            == sys_auth_status[dascc_pkg::DASCC_NS_INV_LSB +: 2])
        else $error("cross-trigger field not copying status");

    AST_CATCH_SHARED: assert property ( // [R14]
        sys_catch_wr && !ext_catch_wr && REALM_OPT
        |=> sys_catch_rdata[dascc_pkg::DASCC_EL2_RET_BIT]
            == $past(sys_catch_wdata[dascc_pkg::DASCC_EL2_RET_BIT])
            ##1 realm_el0_return_en == sys_catch_rdata[dascc_pkg::DASCC_EL0_RET_BIT])
        else $error("shared catch storage not updated");

    AST_EL2_DECODE: assert property ( // [R15]
        catch_word[dascc_pkg::DASCC_EL2_RET_BIT] && !catch_word[dascc_pkg::DASCC_EL2_ENT_BIT]
        && $stable(catch_word) |=> !realm_el2_entry_en && realm_el2_return_en)
        else $error("realm EL2 return-only decode wrong");

endmodule : dascc_ctrl
`default_nettype wire
